// file: src/sphp_pkg.sv
// package: register map, control bit positions, reset values, timing
package sphp_pkg;

  // ---------------------------------------------------------------
  // register offsets (3-bit address)
  // ---------------------------------------------------------------
  localparam int              ADDR_W           = 3;
  localparam logic [2:0]      ADDR_CTRL        = 3'h0;
  localparam logic [2:0]      ADDR_PINS        = 3'h1;
  localparam logic [2:0]      ADDR_LATCHED     = 3'h2;
  localparam logic [2:0]      ADDR_DIR         = 3'h3;
  localparam logic [2:0]      ADDR_PORTB       = 3'h4;

  // ---------------------------------------------------------------
  // handshake_control_status bit positions
  // ---------------------------------------------------------------
  localparam int              BIT_FLAG         = 7;
  localparam int              BIT_IRQ_EN       = 6;
  localparam int              BIT_OPEN_DRAIN   = 5;
  localparam int              BIT_FULL_HS      = 4;
  localparam int              BIT_DIR_SEL      = 3;
  localparam int              BIT_PULSE_SEL    = 2;
  localparam int              BIT_EDGE_SEL     = 1;
  localparam int              BIT_POLARITY     = 0;

  // ---------------------------------------------------------------
  // values after reset, and the all-lines drive mask
  // ---------------------------------------------------------------
  localparam logic [6:0]      CTRL_RESET       = 7'h00;
  localparam logic [7:0]      BYTE_RESET       = 8'h00;
  localparam logic [7:0]      ALL_DRIVEN       = 8'hff;

  // ---------------------------------------------------------------
  // strobe B pulse length in bus clock periods
  // ---------------------------------------------------------------
  localparam int              STROBE_B_OUTPUT_PULSE_CYCLES = 2;
  localparam logic [1:0]      STROBE_B_OUTPUT_PULSE_LAST   =
    2'(STROBE_B_OUTPUT_PULSE_CYCLES - 1);
  localparam logic [1:0]      PULSE_CNT_RESET   = 2'h0;

  // ---------------------------------------------------------------
  // strobe A synchroniser settling depth
  // ---------------------------------------------------------------
  localparam logic [2:0]      PRIME_RESET      = 3'h0;

  // ---------------------------------------------------------------
  // operating mode of the port
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_SIMPLE,
    MODE_IN_HS,
    MODE_OUT_HS
  } sphp_mode_t;

endpackage

// file: src/sphp_strobe_if.sv
// interface: strobe A level and edge between core and synchroniser
`timescale 1ns/1ps
`default_nettype none

interface sphp_strobe_if;
  logic edgeSel;
  logic level;
  logic activeEdge;

  modport sync (
    input  edgeSel,
    output level,
    output activeEdge
  );

  modport core (
    output edgeSel,
    input  level,
    input  activeEdge
  );
endinterface

`default_nettype wire

// file: src/sphp_strobe_sync.sv
// strobe A synchroniser and selectable edge detector
`timescale 1ns/1ps
`default_nettype none

module sphp_strobe_sync (
  input  wire logic clock,      // bus clock
  input  wire logic resetn,     // synchronous reset, active low
  input  wire logic strobeAIn,  // raw strobe A pin
  sphp_strobe_if.sync strobe_b_output      // level and edge towards the core
);

  logic       syncFirst;
  logic       syncSecond;
  logic       prevLevel;
  logic [2:0] primed;
  logic       riseSeen;
  logic       fallSeen;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      syncFirst  <= 1'b0;
      syncSecond <= 1'b0;
      prevLevel  <= 1'b0;
      primed     <= sphp_pkg::PRIME_RESET;
    end else begin
      syncFirst  <= strobeAIn;
      syncSecond <= syncFirst;
      prevLevel  <= syncSecond;
      primed     <= {primed[1:0], 1'b1};
    end
  end

  assign riseSeen = syncSecond & ~prevLevel;
  assign fallSeen = ~syncSecond & prevLevel;

  // edge select picks rising or falling
  assign strobe_b_output.activeEdge = primed[2] & (strobe_b_output.edgeSel ? riseSeen : fallSeen);
  assign strobe_b_output.level      = syncSecond;

endmodule

`default_nettype wire

// file: src/sphp_parallel_port.sv
// strobed and full handshake 8-bit parallel port, device side
`timescale 1ns/1ps
`default_nettype none

module sphp_parallel_port (
  input  wire logic       clock,          // bus clock, 40 MHz
  input  wire logic       resetn,         // synchronous reset, active low
  input  wire logic [2:0] regAddr,        // register address
  input  wire logic [7:0] regWriteData,   // register write data
  input  wire logic       regWrite,       // write strobe
  input  wire logic       regRead,        // read strobe
  output logic      [7:0] regReadData,    // read data, cycle after strobe
  input  wire logic       singleChipMode, // device in single-chip mode
  input  wire logic       globalIrqMask,  // processor interrupt mask
  output logic            irqRequest,     // strobe A interrupt request
  input  wire logic       strobeAIn,      // strobe A pin
  output logic            strobeBOut,     // strobe B pin
  input  wire logic [7:0] portCIn,        // port C pin levels
  output logic      [7:0] portCOut,       // port C drive value
  output logic      [7:0] portCOe,        // port C output enables
  output logic      [7:0] portBOut        // port B output latch
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic regHit(input logic [2:0] addr,
                                  input logic [2:0] offset);
    regHit = (addr == offset);
  endfunction

  logic wrCtrl;
  logic wrPins;
  logic wrLatched;
  logic wrDir;
  logic wrPortB;
  logic rdCtrl;
  logic rdLatched;

  assign wrCtrl    = regWrite & regHit(regAddr, sphp_pkg::ADDR_CTRL);
  assign wrPins    = regWrite & regHit(regAddr, sphp_pkg::ADDR_PINS);
  assign wrLatched = regWrite & regHit(regAddr, sphp_pkg::ADDR_LATCHED);
  assign wrDir     = regWrite & regHit(regAddr, sphp_pkg::ADDR_DIR);
  assign wrPortB   = regWrite & regHit(regAddr, sphp_pkg::ADDR_PORTB);
  assign rdCtrl    = regRead & regHit(regAddr, sphp_pkg::ADDR_CTRL);
  assign rdLatched = regRead & regHit(regAddr, sphp_pkg::ADDR_LATCHED);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [6:0] ctrlBits;
  logic       flag;
  logic       clearArmed;
  logic [7:0] outLatch;
  logic [7:0] latchedC;
  logic [7:0] dirC;
  logic [7:0] portB;
  logic       strbActive;
  logic [1:0] pulseCnt;
  logic [7:0] readData;

  // ---------------------------------------------------------------
  // control fields and mode
  // ---------------------------------------------------------------
  logic irqEn;
  logic openDrain;
  logic fullHs;
  logic dirSel;
  logic pulseSel;
  logic edgeSel;
  logic polarity;

  assign irqEn     = ctrlBits[sphp_pkg::BIT_IRQ_EN];
  assign openDrain = ctrlBits[sphp_pkg::BIT_OPEN_DRAIN];
  assign fullHs    = ctrlBits[sphp_pkg::BIT_FULL_HS];
  assign dirSel    = ctrlBits[sphp_pkg::BIT_DIR_SEL];
  assign pulseSel  = ctrlBits[sphp_pkg::BIT_PULSE_SEL];
  assign edgeSel   = ctrlBits[sphp_pkg::BIT_EDGE_SEL];
  assign polarity  = ctrlBits[sphp_pkg::BIT_POLARITY];

  sphp_pkg::sphp_mode_t mode;

  // direction select ignored in simple mode
  assign mode = !singleChipMode ? sphp_pkg::MODE_OFF    :
                !fullHs         ? sphp_pkg::MODE_SIMPLE :
                !dirSel         ? sphp_pkg::MODE_IN_HS  :
                                  sphp_pkg::MODE_OUT_HS;

  logic modeSimple;
  logic modeInHs;
  logic modeOutHs;
  logic modeHs;

  assign modeSimple = (mode == sphp_pkg::MODE_SIMPLE);
  assign modeInHs   = (mode == sphp_pkg::MODE_IN_HS);
  assign modeOutHs  = (mode == sphp_pkg::MODE_OUT_HS);
  assign modeHs     = modeInHs | modeOutHs;

  // ---------------------------------------------------------------
  // strobe A synchroniser
  // ---------------------------------------------------------------
  sphp_strobe_if strbIf ();

  assign strbIf.edgeSel = edgeSel;

  sphp_strobe_sync u_strobe_sync (
    .clock     (clock),
    .resetn    (resetn),
    .strobeAIn (strobeAIn),
    .strobe_b_output      (strbIf.sync)
  );

  logic strobeEdge;

  assign strobeEdge = strbIf.activeEdge & (mode != sphp_pkg::MODE_OFF);

  // ---------------------------------------------------------------
  // strobe A flag and its clearing sequence
  // ---------------------------------------------------------------
  logic clearAccess;
  logic next_flag;
  logic next_clearArmed;

  // simple and input modes clear on latched read
  // output mode clears on latched write
  assign clearAccess = modeOutHs ? wrLatched : rdLatched;

  // selected edge sets flag, set wins
  assign next_flag = strobeEdge | (flag & ~(clearArmed & clearAccess));

  // arm on a control read that saw the flag set
  assign next_clearArmed = (rdCtrl & flag) ? 1'b1 :
                           clearAccess     ? 1'b0 :
                                             clearArmed;

  assign irqRequest = flag & irqEn & ~globalIrqMask;

  // ---------------------------------------------------------------
  // strobe B sequencing
  // ---------------------------------------------------------------
  logic strbStart;
  logic strbPulsed;
  logic pulseDone;
  logic next_strbActive;
  logic [1:0] next_pulseCnt;

  // in output and simple modes, strobe goes active on the same edge that the latch takes the byte
  // latched write starts strobe B in output mode
  // latched read restarts strobe B in input mode
  // port B write starts a pulse in simple mode
  assign strbStart = (modeSimple & wrPortB) |
                     (modeInHs & rdLatched) |
                     (modeOutHs & wrLatched);

  assign strbPulsed = modeSimple | (modeHs & pulseSel);
  assign pulseDone  = strbActive & strbPulsed &
                      (pulseCnt == sphp_pkg::STROBE_B_OUTPUT_PULSE_LAST);

  // edge ends strobe B in handshake modes
  // input mode edge ends strobe B as well
  assign next_strbActive = (mode == sphp_pkg::MODE_OFF) ? 1'b0 :
                           strbStart                    ? 1'b1 :
                           (strobeEdge & modeHs)        ? 1'b0 :
                           pulseDone                    ? 1'b0 :
                                                          strbActive;

  assign next_pulseCnt = strbStart  ? sphp_pkg::PULSE_CNT_RESET :
                         strbActive ? 2'(pulseCnt + 2'h1)       :
                                      pulseCnt;

  assign strobeBOut = polarity ? strbActive : ~strbActive;

  // ---------------------------------------------------------------
  // port C drive and read views
  // ---------------------------------------------------------------
  logic       forceDrive;
  logic [7:0] driveMask;
  logic [7:0] pinsView;

  // in output mode without open drain, active strobe A level forces all lines out
  // forcing level opposite the edge's final level
  assign forceDrive = modeOutHs & (strbIf.level ^ edgeSel);
  assign driveMask  = forceDrive ? sphp_pkg::ALL_DRIVEN : dirC;

  assign portCOe  = openDrain ? (driveMask & ~outLatch) : driveMask;
  assign portCOut = outLatch;

  // output mode reads the output latch
  assign pinsView = modeOutHs ? outLatch :
                    ((dirC & outLatch) | (~dirC & portCIn));

  logic [7:0] next_readData;

  assign next_readData =
    !regRead                                ? sphp_pkg::BYTE_RESET :
    regHit(regAddr, sphp_pkg::ADDR_CTRL)    ? {flag, ctrlBits}     :
    regHit(regAddr, sphp_pkg::ADDR_PINS)    ? pinsView             :
    regHit(regAddr, sphp_pkg::ADDR_LATCHED) ? latchedC             :
    regHit(regAddr, sphp_pkg::ADDR_DIR)     ? dirC                 :
    regHit(regAddr, sphp_pkg::ADDR_PORTB)   ? portB                :
                                              sphp_pkg::BYTE_RESET;

  assign regReadData = readData;
  assign portBOut    = portB;

  // ---------------------------------------------------------------
  // software-written registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrlBits <= sphp_pkg::CTRL_RESET;
      dirC     <= sphp_pkg::BYTE_RESET;
      portB    <= sphp_pkg::BYTE_RESET;
      outLatch <= sphp_pkg::BYTE_RESET;
    end else begin
      if (wrCtrl) begin
        ctrlBits <= regWriteData[6:0];
      end
      if (wrDir) begin
        dirC <= regWriteData;
      end
      if (wrPortB) begin
        portB <= regWriteData;
      end
      // both port C addresses write the output latch
      if (wrPins | wrLatched) begin
        outLatch <= regWriteData;
      end
    end
  end

  // ---------------------------------------------------------------
  // latched port C capture
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      latchedC <= sphp_pkg::BYTE_RESET;
    end else if (strobeEdge & ~modeOutHs) begin
      // edge captures the pins, flag state ignored
      latchedC <= portCIn;
    end
  end

  // ---------------------------------------------------------------
  // flag, strobe and read data state
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      flag       <= 1'b0;
      clearArmed <= 1'b0;
      strbActive <= 1'b0;
      pulseCnt   <= sphp_pkg::PULSE_CNT_RESET;
      readData   <= sphp_pkg::BYTE_RESET;
    end else begin
      flag       <= next_flag;
      clearArmed <= next_clearArmed;
      strbActive <= next_strbActive;
      pulseCnt   <= next_pulseCnt;
      readData   <= next_readData;
    end
  end

endmodule

`default_nettype wire

// file: tb/sphp_parallel_port_asserts.sv
// checker: port-level assertions for the parallel port
`timescale 1ns/1ps
`default_nettype none

module sphp_parallel_port_asserts (
  input  wire logic       clock,          // bus clock
  input  wire logic       resetn,         // sync reset, low
  input  wire logic [2:0] regAddr,        // address
  input  wire logic [7:0] regWriteData,   // write data
  input  wire logic       regWrite,       // write strobe
  input  wire logic       regRead,        // read strobe
  input  wire logic [7:0] regReadData,    // read data
  input  wire logic       singleChipMode, // single-chip mode
  input  wire logic       globalIrqMask,  // interrupt mask
  input  wire logic       irqRequest,     // interrupt request
  input  wire logic       strobeAIn,      // strobe A pin
  input  wire logic       strobeBOut,     // strobe B pin
  input  wire logic [7:0] portCOut,       // port C value
  input  wire logic [7:0] portCOe,        // port C enables
  input  wire logic [7:0] portBOut        // port B latch
);
  logic [6:0] ctl;
  logic       bAct;
  logic       outHs;
  logic       pbWr;
  assign bAct  = (strobeBOut == ctl[0]);
  assign outHs = ctl[4] & ctl[3];
  assign pbWr  = regWrite && regAddr == sphp_pkg::ADDR_PORTB;
  // shadow of the writable control bits
  always_ff @(posedge clock) begin
    if (!resetn)
      ctl <= 7'h00;
    else if (regWrite && regAddr == sphp_pkg::ADDR_CTRL)
      ctl <= regWriteData[6:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_pbWrite;
    pbWr && !ctl[4] && singleChipMode;
  endsequence
  sequence s_twoQuiet;
    !pbWr [*2];
  endsequence
  a_unmapped_zero: assert property (regRead && regAddr > 3'h4 |=>
    regReadData == 8'h00) else $error("unmapped read not zero");
  a_irq_gated: assert property (globalIrqMask || !ctl[6] |->
    !irqRequest) else $error("interrupt not gated");
  a_open_drain: assert property (ctl[5] |->
    (portCOe & portCOut) == 8'h00) else $error("open drain drives one");
  a_off_mode_idle: assert property ((!singleChipMode) [*3] |->
    strobeBOut == !ctl[0]) else $error("strobe B active off mode");
  a_pulse_two: assert property (s_pbWrite ##1 s_twoQuiet |->
    $past(bAct) && bAct ##1 !bAct) else $error("port B pulse length");
  a_latched_write: assert property (outHs && singleChipMode &&
    regWrite && regAddr == sphp_pkg::ADDR_LATCHED |=>
    portCOut == $past(regWriteData) && bAct) else $error("no ready");
  a_data_steady: assert property (outHs && bAct &&
    !$past(regWrite) |-> $stable(portCOut)) else $error("data moved");
  a_forced_drive: assert property ((outHs && !ctl[5] &&
    singleChipMode && strobeAIn != ctl[1]) [*4] |-> portCOe == 8'hff)
    else $error("port C not forced");
  a_edge_ends_b: assert property (outHs && !ctl[2] &&
    singleChipMode && $fell(strobeAIn) |-> ##[2:6] !bAct)
    else $error("strobe B not ended");
endmodule

bind sphp_parallel_port sphp_parallel_port_asserts u_chk (
  .clock(clock), .resetn(resetn), .regAddr(regAddr),
  .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
  .regReadData(regReadData), .singleChipMode(singleChipMode),
  .globalIrqMask(globalIrqMask), .irqRequest(irqRequest),
  .strobeAIn(strobeAIn), .strobeBOut(strobeBOut), .portCOut(portCOut),
  .portCOe(portCOe), .portBOut(portBOut)
);

`default_nettype wire

// file: tb/sphp_peer.sv
// partner: external device on strobe A, strobe B and port C
`timescale 1ns/1ps
`default_nettype none

module sphp_peer (
  input  wire logic       clock,   // bus clock
  input  wire logic       enable,  // answer strobe B
  input  wire logic       kick,    // lone strobe A pulse
  input  wire logic       activeB, // strobe B active level
  input  wire logic       strobeB, // strobe B pin
  input  wire logic [3:0] lag,     // cycles before acknowledge
  input  wire logic [7:0] pins,    // port C wire level
  output logic            strobeA, // strobe A pin, idles high
  output logic      [7:0] gotByte  // byte taken from port C
);
  logic pulsing = 1'b0;
  assign strobeA = !pulsing;
  initial gotByte = 8'h00;
  always begin
    @(posedge clock);
    if (kick || (enable && strobeB === activeB)) begin
      repeat (lag) @(posedge clock);
      gotByte <= pins;
      pulsing <= 1'b1;
      repeat (4) @(posedge clock);
      pulsing <= 1'b0;
      for (int i = 0; i < 20 && strobeB === activeB; i++)
        @(posedge clock);
    end
  end
endmodule

`default_nettype wire

// file: tb/tb_sphp_parallel_port.sv
// testbench: register-level scenarios for the parallel port
`timescale 1ns/1ps
`default_nettype none

module tb_sphp_parallel_port;
  logic       clock = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWriteData = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic       singleChipMode = 1'b1;
  logic       globalIrqMask = 1'b1;
  logic       peerEn = 1'b0;
  logic       kick = 1'b0;
  logic       pol = 1'b0;
  logic [7:0] peerTx = 8'h00;
  logic [7:0] regReadData, portCIn, portCOut, portCOe, portBOut, gotByte;
  logic [7:0] v;
  logic       irqRequest, strobeA, strobeBOut;
  int         failCount = 0;
  int         nCompared = 0;
  assign portCIn = (portCOe & portCOut) | (~portCOe & peerTx);
  initial begin
    forever #12.5 clock = ~clock;
  end
  sphp_parallel_port dut_u (.clock(clock), .resetn(resetn),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData),
    .singleChipMode(singleChipMode), .globalIrqMask(globalIrqMask),
    .irqRequest(irqRequest), .strobeAIn(strobeA), .strobeBOut(strobeBOut),
    .portCIn(portCIn), .portCOut(portCOut), .portCOe(portCOe),
    .portBOut(portBOut));
  sphp_peer peer_u (.clock(clock), .enable(peerEn), .kick(kick),
    .activeB(pol), .strobeB(strobeBOut), .lag(4'h3), .pins(portCIn),
    .strobeA(strobeA), .gotByte(gotByte));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    d = regReadData;
  endtask
  task automatic rdChk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic waitFlag;
    v = 8'h00;
    for (int i = 0; i < 40 && v[7] !== 1'b1; i++)
      rd(sphp_pkg::ADDR_CTRL, v);
    chkBit(v[7], 1'b1);
  endtask
  task automatic pulseA(input logic [7:0] d);
    peerTx <= d;
    kick <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
  endtask
  task automatic nextCycle;
    @(posedge clock);
    #1;
  endtask
  task automatic endSim;
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    failCount++;
    endSim;
  end
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    chkBit(strobeBOut, 1'b1);
    rdChk(sphp_pkg::ADDR_CTRL, 8'h00);
    wr(sphp_pkg::ADDR_CTRL, 8'h80);
    rdChk(sphp_pkg::ADDR_CTRL, 8'h00);
    wr(3'h6, 8'hff);
    rdChk(3'h6, 8'h00);
    wr(sphp_pkg::ADDR_PORTB, 8'ha5);
    chk(portBOut, 8'ha5);
    chkBit(strobeBOut, 1'b0);
    nextCycle();
    chkBit(strobeBOut, 1'b0);
    nextCycle();
    chkBit(strobeBOut, 1'b1);
    wr(sphp_pkg::ADDR_CTRL, 8'h40);
    pulseA(8'h3c);
    waitFlag();
    chkBit(irqRequest, 1'b0);
    globalIrqMask <= 1'b0;
    #2;
    chkBit(irqRequest, 1'b1);
    rdChk(sphp_pkg::ADDR_LATCHED, 8'h3c);
    chkBit(irqRequest, 1'b0);
    pulseA(8'hc3);
    for (int i = 0; i < 40 && irqRequest !== 1'b1; i++)
      @(posedge clock);
    rdChk(sphp_pkg::ADDR_LATCHED, 8'hc3);
    chkBit(irqRequest, 1'b1);
    rdChk(sphp_pkg::ADDR_CTRL, 8'hc0);
    rdChk(sphp_pkg::ADDR_LATCHED, 8'hc3);
    chkBit(irqRequest, 1'b0);
    globalIrqMask <= 1'b1;
    wr(sphp_pkg::ADDR_CTRL, 8'h11);
    pol <= 1'b1;
    peerTx <= 8'h96;
    chkBit(strobeBOut, 1'b0);
    peerEn <= 1'b1;
    rdChk(sphp_pkg::ADDR_LATCHED, 8'hc3);
    chkBit(strobeBOut, 1'b1);
    waitFlag();
    chkBit(strobeBOut, 1'b0);
    peerEn <= 1'b0;
    rdChk(sphp_pkg::ADDR_LATCHED, 8'h96);
    wr(sphp_pkg::ADDR_CTRL, 8'h18);
    pol <= 1'b0;
    wr(sphp_pkg::ADDR_DIR, 8'h00);
    wr(sphp_pkg::ADDR_LATCHED, 8'h5a);
    chk(portCOut, 8'h5a);
    chkBit(strobeBOut, 1'b0);
    chk(portCOe, 8'hff);
    rdChk(sphp_pkg::ADDR_PINS, 8'h5a);
    peerEn <= 1'b1;
    waitFlag();
    chkBit(strobeBOut, 1'b1);
    chk(gotByte, 8'h5a);
    peerEn <= 1'b0;
    wr(sphp_pkg::ADDR_LATCHED, 8'h6b);
    rdChk(sphp_pkg::ADDR_CTRL, 8'h18);
    wr(sphp_pkg::ADDR_CTRL, 8'h38);
    chk(portCOe, 8'h94);
    wr(sphp_pkg::ADDR_CTRL, 8'h1c);
    wr(sphp_pkg::ADDR_LATCHED, 8'h11);
    chkBit(strobeBOut, 1'b0);
    nextCycle();
    chkBit(strobeBOut, 1'b0);
    nextCycle();
    chkBit(strobeBOut, 1'b1);
    wr(sphp_pkg::ADDR_CTRL, 8'h1a);
    chk(portCOe, 8'h00);
    pulseA(8'h00);
    waitFlag();
    singleChipMode <= 1'b0;
    wr(sphp_pkg::ADDR_CTRL, 8'h00);
    wr(sphp_pkg::ADDR_PORTB, 8'h77);
    chk(portBOut, 8'h77);
    chkBit(strobeBOut, 1'b1);
    nextCycle();
    chkBit(strobeBOut, 1'b1);
    endSim();
  end
endmodule

`default_nettype wire
